// ---- tcc_defs.svh ----
// Register offsets, field positions, reset values and timing constants of the timer channel block.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ==========================================================================
// Register offsets on the byte-wide register port
// ==========================================================================
`define TCC_ADDR_W 4
`define TCC_OFS_SC0 4'h0
`define TCC_OFS_VAL0_HI 4'h1
`define TCC_OFS_VAL0_LO 4'h2
`define TCC_OFS_SC1 4'h3
`define TCC_OFS_VAL1_HI 4'h4
`define TCC_OFS_VAL1_LO 4'h5

// ==========================================================================
// Field positions in a channel status and control register
// ==========================================================================
`define TCC_BIT_FLAG 7
`define TCC_BIT_IRQ_EN 6
`define TCC_BIT_BUF_MODE 5
`define TCC_BIT_UNBUF_MODE 4
`define TCC_BIT_ELS_HI 3
`define TCC_BIT_ELS_LO 2
`define TCC_BIT_TOGGLE_WRAP 1
`define TCC_BIT_FULL_DUTY 0

// ==========================================================================
// Edge and level select encodings
// ==========================================================================
`define TCC_ELS_OFF 2'h0
`define TCC_ELS_RISE_TOGGLE 2'h1
`define TCC_ELS_FALL_CLEAR 2'h2
`define TCC_ELS_ANY_SET 2'h3

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define TCC_SC_RESET 8'h00
`define TCC_RESET_SYNC_STAGES 2
// Least stable time of a pin before capture is enabled, in bus clocks.
`define TCC_PIN_SETTLE_CLKS 2

`endif

// ---- tcc_pkg.sv ----
// Types shared by the timer channel capture and compare block.
package tcc_pkg;

   // =======================================================================
   // Channel operating modes
   // =======================================================================
   typedef enum logic [2:0]
   {
      TCC_MODE_PRESET,
      TCC_MODE_CAPTURE,
      TCC_MODE_COMPARE,
      TCC_MODE_BUFFERED,
      TCC_MODE_OFF
   } tcc_mode_t;

endpackage

// ---- tcc_edge_detect.sv ----
// Active edge detector for one input capture pin.
`timescale 1ns/1ps
`default_nettype none

module tcc_edge_detect
   import tcc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   input wire logic enable_i,
   input wire logic [1:0] edge_sel_i,
   output logic edge_o
);

`include "tcc_defs.svh"

   // ========================================================================
   // Previous pin level
   // ========================================================================
   // The previous level is tracked even while capture is off, so that the
   // first cycle after enabling sees no false edge from stale history.
   logic prev_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prev_q <= 1'b0;
      end
      else
      begin
         prev_q <= pin_i;
      end
   end

   // ========================================================================
   // Edge qualification
   // ========================================================================
   // Rising, falling or either edge, selected by the edge field.
   logic rise;
   logic fall;

   always_comb
   begin
      rise = pin_i & ~prev_q;
      fall = ~pin_i & prev_q;
      edge_o = 1'b0;
      if (enable_i)
      begin
         unique case (edge_sel_i)
            `TCC_ELS_RISE_TOGGLE: edge_o = rise;
            `TCC_ELS_FALL_CLEAR: edge_o = fall;
            `TCC_ELS_ANY_SET: edge_o = rise | fall;
            `TCC_ELS_OFF: edge_o = 1'b0;
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- tcc_top.sv ----
// Two-channel capture, compare and PWM logic referenced to a shared modulo counter.
//
// Function
// - Capture mode: edge code 01 rising, 10 falling, 11 either edge.
// - Unbuffered compare: match toggles pin for 01, clears for 10, sets for 11.
// - Buffered mode select set gives buffered compare or PWM with same actions.
// - Edge field 00 disconnects channel from pin, leaving port control.
// - Once a mode is enabled the channel drives its preset level onto the pin; a capture channel leaves the pin undriven.
// - Reset clears both edge and level select bits of every channel.
// - Compare channel with toggle-on-wrap set toggles its pin at each overflow, or drives the full duty level while force is in effect.
// - Toggle-on-wrap has no effect on a capture channel.
// - Reset clears the toggle-on-wrap bit of each channel.
// - With toggle-on-wrap, overflow action beats a coincident compare action.
// - With toggle-on-wrap set, full duty force gives 100 percent PWM duty.
// - Full duty force changes take effect only from the next PWM period.
// - Value register holds captured count or compare value per mode.
// - Channel value registers are not initialised by reset.
// - Capture mode: high byte read blocks captures until low byte read.
// - Compare mode: high byte write blocks compares until low byte written.
// - Flag set by capture edge or compare match; reset clears; writing 1 ignored.
// - Flag clear needs read with flag set then write 0, void if new event.
// - Buffered mode only on channel 0; it disables channel 1 register and pin.
// - Channel interrupt request is flag and enable, masked for channel 1 while linked; reset clears enable.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tcc_top
   import tcc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [15:0] count_i,
   input wire logic timer_tick_i,
   input wire logic counter_wrap_i,
   input wire logic [1:0] channel_pin_i,
   output logic [1:0] channel_pin_o,
   output logic [1:0] channel_pin_oe_o,
   output logic [1:0] channel_irq_o
);

`include "tcc_defs.svh"

   // ========================================================================
   // Reset release
   // ========================================================================
   // Reset asserts at once and is released through two flops.
   logic [`TCC_RESET_SYNC_STAGES-1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_sync_q <= '0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[`TCC_RESET_SYNC_STAGES-2:0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[`TCC_RESET_SYNC_STAGES-1];

   // ========================================================================
   // Helper functions
   // ========================================================================
   // Mode decode, used for both channels and by several processes.
   function automatic tcc_mode_t mode_of(input logic off, input logic buf_sel,
                                         input logic unbuf_sel, input logic [1:0] els);
      tcc_mode_t m;
      if (off)
         m = TCC_MODE_OFF;
      else if (els == `TCC_ELS_OFF)
         m = TCC_MODE_PRESET;
      else if (buf_sel)
         m = TCC_MODE_BUFFERED;
      else if (unbuf_sel)
         m = TCC_MODE_COMPARE;
      else
         m = TCC_MODE_CAPTURE;
      return m;
   endfunction

   // Pin level after a compare action on the current level.
   function automatic logic compare_level(input logic [1:0] els, input logic cur);
      logic lvl;
      lvl = cur;
      unique case (els)
         `TCC_ELS_RISE_TOGGLE: lvl = ~cur;
         `TCC_ELS_FALL_CLEAR: lvl = 1'b0;
         `TCC_ELS_ANY_SET: lvl = 1'b1;
         `TCC_ELS_OFF: lvl = cur;
      endcase
      return lvl;
   endfunction

   // Active pulse level, the opposite of what a compare would drive.
   // A toggle action has no defined pulse level, so the pin is held.
   function automatic logic full_level(input logic [1:0] els, input logic cur);
      logic lvl;
      lvl = cur;
      if (els == `TCC_ELS_FALL_CLEAR || els == `TCC_ELS_ANY_SET)
         lvl = ~compare_level(els, cur);
      return lvl;
   endfunction

   // ========================================================================
   // Status and control fields
   // ========================================================================
   logic [1:0] flag_q;
   logic [1:0] irq_en_q;
   logic link_q;
   logic [1:0] unbuf_q;
   logic [1:0] els_hi_q;
   logic [1:0] els_lo_q;
   logic [1:0] tov_q;
   logic [1:0] max_q;
   logic [15:0] val_q [0:1];

   // ========================================================================
   // Register port decode
   // ========================================================================
   logic [1:0] wr_sc;
   logic [1:0] rd_sc;
   logic [1:0] wr_hi;
   logic [1:0] wr_lo;
   logic [1:0] rd_hi;
   logic [1:0] rd_lo;

   // Channel 1 control is locked out while the channels are linked.
   always_comb
   begin
      wr_sc[0] = reg_we_i && reg_addr_i == `TCC_OFS_SC0;
      wr_sc[1] = reg_we_i && reg_addr_i == `TCC_OFS_SC1 && !link_q;
      rd_sc[0] = reg_re_i && reg_addr_i == `TCC_OFS_SC0;
      rd_sc[1] = reg_re_i && reg_addr_i == `TCC_OFS_SC1 && !link_q;
      wr_hi[0] = reg_we_i && reg_addr_i == `TCC_OFS_VAL0_HI;
      wr_hi[1] = reg_we_i && reg_addr_i == `TCC_OFS_VAL1_HI;
      wr_lo[0] = reg_we_i && reg_addr_i == `TCC_OFS_VAL0_LO;
      wr_lo[1] = reg_we_i && reg_addr_i == `TCC_OFS_VAL1_LO;
      rd_hi[0] = reg_re_i && reg_addr_i == `TCC_OFS_VAL0_HI;
      rd_hi[1] = reg_re_i && reg_addr_i == `TCC_OFS_VAL1_HI;
      rd_lo[0] = reg_re_i && reg_addr_i == `TCC_OFS_VAL0_LO;
      rd_lo[1] = reg_re_i && reg_addr_i == `TCC_OFS_VAL1_LO;
   end

   // ========================================================================
   // Mode decode per channel
   // ========================================================================
   tcc_mode_t mode [0:1];
   logic [1:0] mode_bits_set;
   logic wrap;

   always_comb
   begin
      mode[0] = mode_of(1'b0, link_q, unbuf_q[0], {els_hi_q[0], els_lo_q[0]});
      mode[1] = mode_of(link_q, 1'b0, unbuf_q[1], {els_hi_q[1], els_lo_q[1]});
      // Channel 1 counts as an output channel while it serves as the buffer.
      mode_bits_set[0] = link_q | unbuf_q[0];
      mode_bits_set[1] = link_q | unbuf_q[1];
      wrap = counter_wrap_i & timer_tick_i;
   end

   // ========================================================================
   // Control bits
   // ========================================================================
   // Software writes take the new mode at once; software is expected to stop
   // and reset the counter before changing a channel function.
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_en_q <= 2'h0;
         link_q <= 1'b0;
         unbuf_q <= 2'h0;
         els_hi_q <= 2'h0;
         els_lo_q <= 2'h0;
         tov_q <= 2'h0;
         max_q <= 2'h0;
      end
      else
      begin
         for (int x = 0; x < 2; x++)
         begin
            if (wr_sc[x])
            begin
               irq_en_q[x] <= reg_wdata_i[`TCC_BIT_IRQ_EN];
               unbuf_q[x] <= reg_wdata_i[`TCC_BIT_UNBUF_MODE];
               els_hi_q[x] <= reg_wdata_i[`TCC_BIT_ELS_HI];
               els_lo_q[x] <= reg_wdata_i[`TCC_BIT_ELS_LO];
               tov_q[x] <= reg_wdata_i[`TCC_BIT_TOGGLE_WRAP];
               max_q[x] <= reg_wdata_i[`TCC_BIT_FULL_DUTY];
            end
         end
         if (wr_sc[0])
         begin
            link_q <= reg_wdata_i[`TCC_BIT_BUF_MODE];
         end
      end
   end

   // ========================================================================
   // Capture edge detection
   // ========================================================================
   // The outside source must keep the pin steady for two bus clocks before
   // capture is enabled, otherwise the first edge may be spurious.
   logic [1:0] edge_hit;

   for (genvar g = 0; g < 2; g++)
   begin : g_edge
      tcc_edge_detect u_edge
      (
         .ref_clk_i(ref_clk_i),
         .rst_n_i(rst_n),
         .pin_i(channel_pin_i[g]),
         .enable_i(mode[g] == TCC_MODE_CAPTURE),
         .edge_sel_i({els_hi_q[g], els_lo_q[g]}),
         .edge_o(edge_hit[g])
      );
   end

   // ========================================================================
   // Byte access interlocks
   // ========================================================================
   logic [1:0] cap_block_q;
   logic [1:0] cmp_block_q;

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_block_q <= 2'h0;
         cmp_block_q <= 2'h0;
      end
      else
      begin
         for (int x = 0; x < 2; x++)
         begin
            if (rd_lo[x])
               cap_block_q[x] <= 1'b0;
            else if (rd_hi[x] && !mode_bits_set[x])
               cap_block_q[x] <= 1'b1;
            if (wr_lo[x])
               cmp_block_q[x] <= 1'b0;
            else if (wr_hi[x] && mode_bits_set[x])
               cmp_block_q[x] <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Buffer selection
   // ========================================================================
   // The controlling register only changes at overflow, so a new value never
   // cuts a PWM period short.
   logic active_sel_q;
   logic last_wr_q;

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_sel_q <= 1'b0;
         last_wr_q <= 1'b0;
      end
      else
      begin
         if (wr_hi[1] || wr_lo[1])
            last_wr_q <= 1'b1;
         else if (wr_hi[0] || wr_lo[0])
            last_wr_q <= 1'b0;
         if (!link_q)
            active_sel_q <= 1'b0;
         else if (wrap)
            active_sel_q <= last_wr_q;
      end
   end

   // ========================================================================
   // Capture and compare events
   // ========================================================================
   logic [1:0] cap_hit;
   logic [1:0] cmp_hit;
   logic [15:0] cmp_val0;
   logic cmp_block0;

   always_comb
   begin
      cmp_val0 = active_sel_q ? val_q[1] : val_q[0];
      cmp_block0 = active_sel_q ? cmp_block_q[1] : cmp_block_q[0];
      for (int x = 0; x < 2; x++)
      begin
         cap_hit[x] = edge_hit[x] && !cap_block_q[x];
      end
      cmp_hit[0] = timer_tick_i && (count_i == cmp_val0) && !cmp_block0 &&
                   (mode[0] == TCC_MODE_COMPARE || mode[0] == TCC_MODE_BUFFERED);
      cmp_hit[1] = timer_tick_i && (count_i == val_q[1]) && !cmp_block_q[1] &&
                   mode[1] == TCC_MODE_COMPARE;
   end

   // ========================================================================
   // Channel value registers
   // ========================================================================
   // No reset on purpose: contents are undefined until written or captured.
   always_ff @(posedge ref_clk_i)
   begin
      for (int x = 0; x < 2; x++)
      begin
         if (cap_hit[x])
            val_q[x] <= count_i;
         else
         begin
            if (wr_hi[x])
               val_q[x][15:8] <= reg_wdata_i;
            if (wr_lo[x])
               val_q[x][7:0] <= reg_wdata_i;
         end
      end
   end

   // ========================================================================
   // Event flags
   // ========================================================================
   // A clear is armed by reading the flag set; any new event disarms it, so
   // an event is never lost to a late clear. A set beats a clear.
   logic [1:0] clr_arm_q;
   logic [1:0] evt;

   assign evt = cap_hit | cmp_hit;

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_q <= 2'h0;
         clr_arm_q <= 2'h0;
      end
      else
      begin
         for (int x = 0; x < 2; x++)
         begin
            if (evt[x])
            begin
               flag_q[x] <= 1'b1;
               clr_arm_q[x] <= 1'b0;
            end
            else if (wr_sc[x])
            begin
               if (clr_arm_q[x] && !reg_wdata_i[`TCC_BIT_FLAG])
                  flag_q[x] <= 1'b0;
               clr_arm_q[x] <= 1'b0;
            end
            else if (rd_sc[x] && flag_q[x])
               clr_arm_q[x] <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Full duty latch
   // ========================================================================
   // The force bit is sampled only at overflow, so it acts from the next period.
   logic [1:0] max_eff_q;

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         max_eff_q <= 2'h0;
      end
      else if (wrap)
      begin
         max_eff_q <= max_q;
      end
   end

   // ========================================================================
   // Output level
   // ========================================================================
   logic [1:0] out_q;
   logic [1:0] full_duty;

   always_comb
   begin
      for (int x = 0; x < 2; x++)
      begin
         full_duty[x] = tov_q[x] && max_eff_q[x];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_q <= 2'h3;
      end
      else
      begin
         for (int x = 0; x < 2; x++)
         begin
            unique case (mode[x])
               TCC_MODE_PRESET, TCC_MODE_OFF, TCC_MODE_CAPTURE:
                  out_q[x] <= ~unbuf_q[x];
               TCC_MODE_COMPARE, TCC_MODE_BUFFERED:
               begin
                  if (wrap && tov_q[x])
                  begin
                     if (full_duty[x])
                        out_q[x] <= full_level({els_hi_q[x], els_lo_q[x]}, out_q[x]);
                     else
                        out_q[x] <= ~out_q[x];
                  end
                  else if (cmp_hit[x] && !full_duty[x])
                     out_q[x] <= compare_level({els_hi_q[x], els_lo_q[x]}, out_q[x]);
               end
            endcase
         end
      end
   end

   // ========================================================================
   // Pins and interrupt requests
   // ========================================================================
   // The pin is driven only in output modes, starting from the preset level.
   always_comb
   begin
      for (int x = 0; x < 2; x++)
      begin
         channel_pin_oe_o[x] = mode[x] == TCC_MODE_COMPARE || mode[x] == TCC_MODE_BUFFERED;
         channel_irq_o[x] = flag_q[x] && irq_en_q[x] && mode[x] != TCC_MODE_OFF;
      end
      channel_pin_o = out_q;
   end

   // ========================================================================
   // Read data
   // ========================================================================
   // Read data appear the cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_o <= 8'h00;
      end
      else if (reg_re_i)
      begin
         unique case (reg_addr_i)
            `TCC_OFS_SC0:
               reg_rdata_o <= {flag_q[0], irq_en_q[0], link_q, unbuf_q[0],
                               els_hi_q[0], els_lo_q[0], tov_q[0], max_q[0]};
            `TCC_OFS_SC1:
               reg_rdata_o <= link_q ? `TCC_SC_RESET :
                              {flag_q[1], irq_en_q[1], 1'b0, unbuf_q[1],
                               els_hi_q[1], els_lo_q[1], tov_q[1], max_q[1]};
            `TCC_OFS_VAL0_HI: reg_rdata_o <= val_q[0][15:8];
            `TCC_OFS_VAL0_LO: reg_rdata_o <= val_q[0][7:0];
            `TCC_OFS_VAL1_HI: reg_rdata_o <= val_q[1][15:8];
            `TCC_OFS_VAL1_LO: reg_rdata_o <= val_q[1][7:0];
            default: reg_rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// ---- tcc_pin_model.sv ----
// Outside signal source model for the two channel pins.
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic [1:0] level_i,
   input wire logic [1:0] dut_pin_i,
   input wire logic [1:0] dut_oe_i,
   output logic [1:0] pin_o
);
   logic [1:0] lag_q = 2'h0;
   logic [1:0] ext_q = 2'h0;
   // A slow source adds a clock of lag; a level is held until the next request.
   always_ff @(posedge clk_i)
   begin
      lag_q <= level_i;
      ext_q <= slow_i ? lag_q : level_i;
   end
   // The block wins the wire while it drives the pin.
   assign pin_o = (dut_oe_i & dut_pin_i) | (~dut_oe_i & ext_q);
endmodule
`default_nettype wire

// ---- tcc_top_checker.sv ----
// Port assertions for the timer channel block.
`timescale 1ns/1ps
`default_nettype none
module tcc_checker (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [15:0] count_i,
   input wire logic timer_tick_i,
   input wire logic counter_wrap_i,
   input wire logic [1:0] channel_pin_i,
   input wire logic [1:0] channel_pin_o,
   input wire logic [1:0] channel_pin_oe_o,
   input wire logic [1:0] channel_irq_o
);
   logic [1:0] we_q, tk_q, p1_q, p2_q, p3_q, moved;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // History of strobes, ticks and pins, since events land one or two cycles late.
   always_ff @(posedge ref_clk_i)
   begin
      we_q <= {we_q[0], reg_we_i};
      tk_q <= {tk_q[0], timer_tick_i};
      p1_q <= channel_pin_i;
      p2_q <= p1_q;
      p3_q <= p2_q;
   end
   assign moved = (p1_q ^ p2_q) | (p2_q ^ p3_q);
   rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its slot");
   unmapped_read_a: assert property (reg_re_i && reg_addr_i > 4'h5 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   sc1_link_zero_a: assert property (reg_re_i && reg_addr_i == 4'h3 |=> !reg_rdata_o[5])
      else $error("link bit seen in channel 1");
   irq0_cause_a: assert property ($rose(channel_irq_o[0]) |-> we_q[0] || tk_q != 2'h0 || moved[0])
      else $error("channel 0 request without cause");
   irq1_cause_a: assert property ($rose(channel_irq_o[1]) |-> we_q[0] || tk_q != 2'h0 || moved[1])
      else $error("channel 1 request without cause");
   irq_fall_a: assert property (|($past(channel_irq_o) & ~channel_irq_o) |-> we_q[0])
      else $error("request dropped without a write");
   oe_change_a: assert property (channel_pin_oe_o != $past(channel_pin_oe_o) |-> we_q[0])
      else $error("pin enable moved without a write");
   pin_change_a: assert property (channel_pin_o != $past(channel_pin_o) |-> we_q != 2'h0 || tk_q != 2'h0)
      else $error("pin moved without write or tick");
   read_seen_c: cover property (reg_re_i ##1 reg_rdata_o != 8'h00);
   oe_on_c: cover property ($rose(channel_pin_oe_o[0]));
   irq_on_c: cover property ($rose(channel_irq_o[0]));
endmodule
bind tcc_top tcc_checker i_checker (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
   .reg_rdata_o, .count_i, .timer_tick_i, .counter_wrap_i, .channel_pin_i, .channel_pin_o, .channel_pin_oe_o,
   .channel_irq_o);
`default_nettype wire

// ---- tb_timer_channel_capture_compare.sv ----
// Self-checking bench for the timer channel block.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_capture_compare;
   `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); end end
   logic clk = 0, rst_n = 0, we = 0, re = 0, tk = 0, wrap = 0, slow = 0, ep = 1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, rd_v, rdo, cfg;
   logic [15:0] cnt = 16'h0000, c, v, expv;
   logic [1:0] lvl = 2'h0, pin_i, pin_o, oe, irq;
   logic [31:0] seed = 32'h00001020;
   int n_errors = 0, n_compared = 0, cyc = 0;
   tcc_top i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
      .reg_re_i(re), .reg_rdata_o(rdo), .count_i(cnt), .timer_tick_i(tk), .counter_wrap_i(wrap),
      .channel_pin_i(pin_i), .channel_pin_o(pin_o), .channel_pin_oe_o(oe), .channel_irq_o(irq));
   tcc_pin_model i_src (.clk_i(clk), .slow_i(slow), .level_i(lvl), .dut_pin_i(pin_o), .dut_oe_i(oe), .pin_o(pin_i));
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   initial
   begin
      forever #10 clk = ~clk;
   end
   // A hang is cut short well above the few hundred cycles the run needs.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         close_out();
      end
   end
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wd <= d; we <= 1;
      @(posedge clk);
      we <= 0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
   task rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a; re <= 1;
      @(posedge clk);
      re <= 0;
      @(negedge clk);
      rd_v = rdo;
   endtask
   task tick(input logic [15:0] n, input logic w);
      @(posedge clk);
      cnt <= n; wrap <= w; tk <= 1;
      @(posedge clk);
      tk <= 0; wrap <= 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   // The count is held until the next move, so a capture late by a clock still sees it.
   task move(input logic lv, input logic [15:0] n);
      @(posedge clk);
      cnt <= n; lvl[0] <= lv;
      repeat (5) @(posedge clk);
   endtask
   task close_out();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      `CHK("pin", 2'h3, pin_o)
      `CHK("oe", 2'h0, oe)
      for (int a = 0; a < 16; a++)
         if (a % 3 == 0 || a > 5)
         begin
            rd(a[3:0]);
            `CHK("reset read", 8'h00, rd_v)
         end
      // Capture: the model keeps the count of the last active edge.
      for (int e = 1; e < 4; e++)
      begin
         cfg = 8'(e << 2) | 8'h02;
         wr(4'h0, cfg);
         slow <= e[0];
         for (int k = 0; k < 2; k++)
         begin
            c = rnd();
            if (lvl[0] ? e[1] : e[0]) expv = c;
            move(~lvl[0], c);
         end
         rd(4'h0);
         `CHK("flag", 1'b1, rd_v[7])
         wr(4'h0, cfg);
         rd(4'h0);
         `CHK("flag clear", 1'b0, rd_v[7])
         rd(4'h1);
         `CHK("cap hi", expv[15:8], rd_v)
         move(~lvl[0], rnd());
         rd(4'h2);
         `CHK("cap lo", expv[7:0], rd_v)
      end
      // Compare codes set, clear and toggle, each first held off by a lone high byte.
      v = rnd();
      for (int e = 3; e > 0; e--)
      begin
         wr(4'h0, 8'h50 | 8'(e << 2));
         wr(4'h1, v[15:8]);
         tick(v, 0);
         `CHK("held", ep, pin_o[0])
         wr(4'h2, v[7:0]);
         tick(v, 0);
         ep = (e == 3) ? 1'b1 : (e == 2) ? 1'b0 : ~ep;
         `CHK("cmp pin", ep, pin_o[0])
      end
      `CHK("irq", 2'h1, irq)
      `CHK("oe on", 2'h1, oe)
      wr(4'h0, 8'h5e);
      tick(v, 1);
      `CHK("wrap wins", 1'b0, pin_o[0])
      tick(v + 16'h0001, 1);
      `CHK("wrap toggle", 1'b1, pin_o[0])
      // Full duty starts one period late and outlives its clear by one period.
      wr(4'h0, 8'h5f);
      tick(16'h0000, 1);
      tick(v, 0);
      `CHK("full duty", 1'b0, pin_o[0])
      wr(4'h0, 8'h5e);
      tick(v, 0);
      `CHK("duty latch", 1'b0, pin_o[0])
      wr(4'h3, 8'h5e);
      rd(4'h3);
      `CHK("sc1", 8'h5e, rd_v)
      wr(4'h0, 8'h7e);
      rd(4'h3);
      `CHK("sc1 linked", 8'h00, rd_v)
      `CHK("oe1 linked", 1'b0, oe[1])
      // Linked pair: the channel 1 value takes over at the next overflow.
      wr(4'h4, ~v[15:8]);
      wr(4'h5, ~v[7:0]);
      tick(16'h0000, 1);
      tick(~v, 0);
      `CHK("buffered", 1'b1, pin_o[0])
      close_out();
   end
endmodule
`default_nettype wire
